/* src/bcr_cfg.svh */
// constants for the branch, call and return execution unit
// assumes one clock cycle per processor clock state
`ifndef BCR_CFG_SVH
`define BCR_CFG_SVH

// ******
// opcodes and opcode fields
// ******
`define BCR_OP_REL 8'h18
`define BCR_OP_LOOP 8'h10
`define BCR_OP_ABS 8'hc3
`define BCR_OP_CALL 8'hcd
`define BCR_OP_EXIT 8'hc9
`define BCR_OP_MI_EXIT 8'h4d
`define BCR_OP_NMI_EXIT 8'h45
`define BCR_TOP_RELCC 3'h1
`define BCR_TOP_GRP 2'h3
`define BCR_LOW_RELCC 3'h0
`define BCR_LOW_ABSCC 3'h2
`define BCR_LOW_CALLCC 3'h4
`define BCR_LOW_EXITCC 3'h0
`define BCR_LOW_RST 3'h7

// ******
// flag bit positions
// ******
`define BCR_FLAG_C 0
`define BCR_FLAG_PV 2
`define BCR_FLAG_Z 6
`define BCR_FLAG_S 7

// ******
// clock states per instruction and outcome
// ******
`define BCR_T_REL_TAKEN 5'h0c
`define BCR_T_REL_SKIP 5'h07
`define BCR_T_LOOP_TAKEN 5'h0d
`define BCR_T_LOOP_SKIP 5'h08
`define BCR_T_ABS 5'h0a
`define BCR_T_CALL 5'h11
`define BCR_T_CALL_SKIP 5'h0a
`define BCR_T_RET 5'h0a
`define BCR_T_RETCC_TAKEN 5'h0b
`define BCR_T_RETCC_SKIP 5'h05
`define BCR_T_RST 5'h0b
`define BCR_T_INT_EXIT 5'h0e
`define BCR_T_UNSUP 5'h04

// ******
// register map and reset values
// ******
`define BCR_REG_CTRL 4'h0
`define BCR_REG_STATUS 4'h1
`define BCR_REG_LAST_T 4'h2
`define BCR_REG_TAKEN_CNT 4'h3
`define BCR_REG_LAST_OP 4'h4
`define BCR_CTRL_RESET 8'h01
`define BCR_CTRL_EN_BIT 0

`endif

/* src/bcr_pkg.sv */
// types for the branch, call and return execution unit
// assumes nothing of its surroundings
package bcr_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PUSH_HI = 3'b001,
    ST_PUSH_LO = 3'b010,
    ST_POP_LO = 3'b011,
    ST_POP_HI = 3'b100,
    ST_WAIT = 3'b101
  } bcr_state_e;
endpackage

/* src/bcr_cond_eval.sv */
// condition field evaluator for conditional transfers
// assumes flags laid out sign, zero, -, half, -, parity, subtract, carry
`timescale 1ns/1ps
`default_nettype none
`include "bcr_cfg.svh"

module bcr_cond_eval (
  input wire logic [2:0] sel_i,   // condition field
  input wire logic [7:0] flags_i, // flag register
  output logic true_o             // condition holds
);
  // ******
  // condition decode
  // ******
  logic [7:0] cond_vec;
  assign cond_vec[0] = ~flags_i[`BCR_FLAG_Z];  // cond_nonzero; see [RQ11]
  assign cond_vec[1] = flags_i[`BCR_FLAG_Z];
  assign cond_vec[2] = ~flags_i[`BCR_FLAG_C];
  assign cond_vec[3] = flags_i[`BCR_FLAG_C];
  assign cond_vec[4] = ~flags_i[`BCR_FLAG_PV]; // cond_parity_odd
  assign cond_vec[5] = flags_i[`BCR_FLAG_PV];  // cond_parity_even; see [RQ11]
  assign cond_vec[6] = ~flags_i[`BCR_FLAG_S];  // positive; see [RQ11]
  assign cond_vec[7] = flags_i[`BCR_FLAG_S];   // negative; see [RQ11]
  assign true_o = cond_vec[sel_i];
endmodule
`default_nettype wire

/* src/bcr_unit.sv */
// branch, call and return execution unit of an 8-bit processor core
// assumes decode hands over one opcode with its operands per EXEC_I pulse,
// and a byte-wide memory port that answers reads in the following cycle
//
// Functional notes
// [RQ1] Branch-if-zero relative with zero set adds the displacement in 3 machine cycles and 12 states.
// [RQ2] Branch-if-not-zero relative falls through in 7 states with zero set, else branches in 12.
// [RQ3] The loop branch decrements B and falls through in 8 states on zero, else branches in 13.
// [RQ4] The displacement is signed two's complement, reaching -126 to 129 from the instruction.
// [RQ5] The program counter is advanced by 2 before the displacement is added.
// [RQ6] The encoder places target offset minus two in the displacement byte.
// [RQ7] No transfer in this group changes any flag.
// [RQ8] A conditional call skips in 10 states when false and does a full call in 17 when true.
// [RQ9] Restart takes its vector 00h to 38h in steps of eight from a 3-bit opcode field.
// [RQ10] Restart pushes the high byte to stack minus one, low to minus two, then jumps in 11 states.
// [RQ11] The condition field decodes non-zero, zero, no carry, carry, odd, even, positive, negative.
// [RQ12] A call pushes the return address high then low below the stack, drops it by two, and jumps.
// [RQ13] A taken return pops the low byte then the high byte and raises the stack pointer by two.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "bcr_cfg.svh"

module bcr_unit
  import bcr_pkg::*;
(
  input wire logic CLK_I,               // core clock
  input wire logic RESETN_I,            // async reset, active low
  input wire logic CE_I,                // clock enable
  input wire logic EXEC_I,              // start one instruction
  input wire logic PREFIX_ED_I,         // opcode follows the ed prefix
  input wire logic [7:0] OPCODE_I,      // opcode byte
  input wire logic [15:0] OPERAND_I,    // immediate word, displacement in low byte
  input wire logic [15:0] PC_I,         // address of the instruction
  input wire logic [15:0] SP_I,         // stack pointer
  input wire logic [7:0] B_I,           // loop counter register
  input wire logic [7:0] FLAGS_I,       // flag register
  input wire logic [7:0] MEM_RDATA_I,   // stack read data
  input wire logic [3:0] REG_ADDR_I,    // register address
  input wire logic [7:0] REG_WDATA_I,   // register write data
  input wire logic REG_WR_I,            // register write strobe
  input wire logic REG_RD_I,            // register read strobe
  output logic BUSY_O,                  // instruction in progress
  output logic DONE_O,                  // results valid, one cycle
  output logic TAKEN_O,                 // transfer was taken
  output logic UNSUP_O,                 // opcode not in this group
  output logic [15:0] PC_O,             // new program counter
  output logic [15:0] SP_O,             // new stack pointer
  output logic [7:0] B_O,               // new loop counter
  output logic [7:0] FLAGS_O,           // flags, untouched
  output logic [1:0] BYTES_O,           // instruction length
  output logic [2:0] MCYC_O,            // machine cycles used
  output logic [4:0] TSTATES_O,         // clock states used
  output logic MEM_WR_O,                // stack write strobe
  output logic MEM_RD_O,                // stack read strobe
  output logic [15:0] MEM_ADDR_O,       // stack address
  output logic [7:0] MEM_WDATA_O,       // stack write data
  output logic [7:0] REG_RDATA_O        // register read data
);

  // ******
  // state
  // ******
  // results latched at accept, shown at done
  bcr_state_e state;
  bcr_state_e next_state;
  logic [4:0] tcnt;
  logic [4:0] t_need;
  logic pop_tail;
  logic [15:0] res_pc;
  logic [15:0] res_sp;
  logic [7:0] res_b;
  logic [7:0] res_flags;
  logic [15:0] ret_lat;
  logic res_taken;
  logic res_unsup;
  logic [1:0] res_bytes;
  logic [2:0] res_mcyc;
  logic [7:0] ctrl;
  logic [7:0] taken_cnt;
  logic [7:0] last_op;
  logic last_cond;

  // ******
  // opcode decode
  // ******
  wire logic plain = ~PREFIX_ED_I;
  wire logic grp = plain & (OPCODE_I[7:6] == `BCR_TOP_GRP);
  wire logic is_relb = plain & (OPCODE_I == `BCR_OP_REL);
  wire logic is_jrcc = plain & (OPCODE_I[7:5] == `BCR_TOP_RELCC) & (OPCODE_I[2:0] == `BCR_LOW_RELCC);
  wire logic is_loop = plain & (OPCODE_I == `BCR_OP_LOOP);
  wire logic is_abs = plain & (OPCODE_I == `BCR_OP_ABS);
  wire logic is_jpcc = grp & (OPCODE_I[2:0] == `BCR_LOW_ABSCC);
  wire logic is_call = plain & (OPCODE_I == `BCR_OP_CALL);
  wire logic is_callcc = grp & (OPCODE_I[2:0] == `BCR_LOW_CALLCC);
  wire logic is_exit = plain & (OPCODE_I == `BCR_OP_EXIT);
  wire logic is_retcc = grp & (OPCODE_I[2:0] == `BCR_LOW_EXITCC);
  wire logic is_rst = grp & (OPCODE_I[2:0] == `BCR_LOW_RST);
  wire logic is_int_exit = PREFIX_ED_I & ((OPCODE_I == `BCR_OP_MI_EXIT) | (OPCODE_I == `BCR_OP_NMI_EXIT));
  wire logic is_rel = is_relb | is_jrcc | is_loop;
  wire logic is_known = is_rel | is_abs | is_jpcc | is_call | is_callcc | is_exit | is_retcc | is_rst | is_int_exit;

  // ******
  // conditions
  // ******
  // flags are only read, never written here
  wire logic cond_ok;
  // relative branches only reach the first four codes
  wire logic [2:0] cond_sel = is_jrcc ? {1'b0, OPCODE_I[4:3]} : OPCODE_I[5:3];
  wire logic [7:0] b_dec = B_I - 8'h01;           // see [RQ3]
  wire logic loop_go = is_loop & (b_dec != 8'h00); // see [RQ3]

  bcr_cond_eval u_cond (
    .sel_i(cond_sel),
    .flags_i(FLAGS_I),
    .true_o(cond_ok)
  );

  wire logic cc_go = (is_jrcc | is_jpcc | is_callcc | is_retcc) & cond_ok; // see [RQ1] [RQ2] [RQ11]
  wire logic go = is_relb | is_abs | is_call | is_exit | is_int_exit | is_rst | cc_go | loop_go;
  wire logic do_push = go & (is_call | is_callcc | is_rst);  // see [RQ8] [RQ10] [RQ12]
  wire logic do_pop = go & (is_exit | is_retcc | is_int_exit); // see [RQ13]

  // ******
  // lengths and timing
  // ******
  wire logic [1:0] bytes_sel = (is_abs | is_jpcc | is_call | is_callcc) ? 2'h3 :
                               (is_rel | is_int_exit) ? 2'h2 : 2'h1;
  wire logic [4:0] t_sel =
    ~is_known ? `BCR_T_UNSUP :
    is_rel & ~is_loop ? (go ? `BCR_T_REL_TAKEN : `BCR_T_REL_SKIP) :   // see [RQ1] [RQ2]
    is_loop ? (go ? `BCR_T_LOOP_TAKEN : `BCR_T_LOOP_SKIP) :           // see [RQ3]
    (is_abs | is_jpcc) ? `BCR_T_ABS :
    (is_call | is_callcc) ? (go ? `BCR_T_CALL : `BCR_T_CALL_SKIP) :   // see [RQ8]
    is_exit ? `BCR_T_RET :
    is_retcc ? (go ? `BCR_T_RETCC_TAKEN : `BCR_T_RETCC_SKIP) :
    is_rst ? `BCR_T_RST :                                             // see [RQ10]
    `BCR_T_INT_EXIT;
  wire logic [2:0] m_sel =
    ~is_known ? 3'h1 :
    (is_rel | is_retcc) ? (go ? 3'h3 : (is_retcc ? 3'h1 : 3'h2)) :    // see [RQ1]
    (is_call | is_callcc) ? (go ? 3'h5 : 3'h3) :
    is_int_exit ? 3'h4 : 3'h3;

  // ******
  // targets
  // ******
  // all sums wrap at 16 bits
  wire logic [15:0] fall_pc = PC_I + {14'h0000, bytes_sel};
  // counter already past opcode and displacement; see [RQ5] [RQ6]
  wire logic [15:0] adv_pc = PC_I + 16'h0002;
  // sign extended displacement; see [RQ4]
  wire logic [15:0] disp = {{8{OPERAND_I[7]}}, OPERAND_I[7:0]};
  wire logic [15:0] rel_pc = adv_pc + disp;                            // see [RQ1] [RQ2] [RQ3]
  wire logic [15:0] rst_pc = {8'h00, 2'b00, OPCODE_I[5:3], 3'b000};   // see [RQ9] [RQ10]
  wire logic [15:0] tgt_pc =
    ~go ? fall_pc :
    is_rel ? rel_pc :
    is_rst ? rst_pc : OPERAND_I;                                       // see [RQ12]
  wire logic [15:0] tgt_sp = do_push ? SP_I - 16'h0002 :              // see [RQ12]
                             do_pop ? SP_I + 16'h0002 : SP_I;          // see [RQ13]

  // ******
  // stack sequencing
  // ******
  // pushes and pops run ahead of the state count;
  // pop_tail holds off finish until the high byte lands
  wire logic accept = EXEC_I & (state == ST_IDLE) & ctrl[`BCR_CTRL_EN_BIT];
  wire logic finish = (state == ST_WAIT) & ~pop_tail & (tcnt == t_need);
  wire logic [15:0] sp_cur = (state == ST_IDLE) ? SP_I : res_sp;
  wire logic [15:0] ret_cur = (state == ST_IDLE) ? fall_pc : ret_lat;
  // stack base seen before the pointer moved
  wire logic [15:0] sp_base = (state == ST_IDLE) ? sp_cur :
                              (next_state == ST_PUSH_HI || next_state == ST_PUSH_LO) ? sp_cur + 16'h0002 :
                              sp_cur - 16'h0002;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (accept) begin
          next_state = do_push ? ST_PUSH_HI : (do_pop ? ST_POP_LO : ST_WAIT);
        end
      end
      ST_PUSH_HI: next_state = ST_PUSH_LO;
      ST_PUSH_LO: next_state = ST_WAIT;
      ST_POP_LO: next_state = ST_POP_HI;
      ST_POP_HI: next_state = ST_WAIT;
      ST_WAIT: begin
        if (finish) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  wire logic nx_push_hi = (next_state == ST_PUSH_HI);
  wire logic nx_push_lo = (next_state == ST_PUSH_LO);
  wire logic nx_pop_lo = (next_state == ST_POP_LO);
  wire logic nx_pop_hi = (next_state == ST_POP_HI);
  wire logic [15:0] next_addr =
    nx_push_hi ? sp_base - 16'h0001 :       // see [RQ10] [RQ12]
    nx_push_lo ? sp_base - 16'h0002 :       // see [RQ10] [RQ12]
    nx_pop_lo ? sp_base :                   // see [RQ13]
    nx_pop_hi ? sp_base + 16'h0001 : 16'h0000;
  wire logic [7:0] next_wdata = nx_push_hi ? ret_cur[15:8] : (nx_push_lo ? ret_cur[7:0] : 8'h00);

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state <= ST_IDLE;
      tcnt <= 5'h00;
      pop_tail <= 1'b0;
    end else if (CE_I) begin
      state <= next_state;
      tcnt <= accept ? 5'h01 : tcnt + 5'h01;
      pop_tail <= (state == ST_POP_HI);
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      MEM_WR_O <= 1'b0;
      MEM_RD_O <= 1'b0;
      MEM_ADDR_O <= 16'h0000;
      MEM_WDATA_O <= 8'h00;
    end else if (CE_I) begin
      MEM_WR_O <= nx_push_hi | nx_push_lo;
      MEM_RD_O <= nx_pop_lo | nx_pop_hi;
      MEM_ADDR_O <= next_addr;
      MEM_WDATA_O <= next_wdata;
    end
  end

  // ******
  // result capture
  // ******
  // popped bytes overwrite the latched target
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      res_pc <= 16'h0000;
      res_sp <= 16'h0000;
      res_b <= 8'h00;
      res_flags <= 8'h00;
      ret_lat <= 16'h0000;
      t_need <= 5'h00;
      res_taken <= 1'b0;
      res_unsup <= 1'b0;
      res_bytes <= 2'h0;
      res_mcyc <= 3'h0;
    end else if (CE_I) begin
      if (accept) begin
        res_pc <= tgt_pc;
        res_sp <= tgt_sp;
        res_b <= is_loop ? b_dec : B_I;  // see [RQ3]
        res_flags <= FLAGS_I;            // flags pass untouched; see [RQ7]
        ret_lat <= fall_pc;
        t_need <= t_sel;
        res_taken <= go;
        res_unsup <= ~is_known;
        res_bytes <= bytes_sel;
        res_mcyc <= m_sel;
      end else if (state == ST_POP_HI) begin
        res_pc[7:0] <= MEM_RDATA_I;      // low byte from stack top; see [RQ13]
      end else if (pop_tail) begin
        res_pc[15:8] <= MEM_RDATA_I;     // high byte from next location; see [RQ13]
      end
    end
  end

  // ******
  // result outputs
  // ******
  // outputs hold until the next done pulse
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      DONE_O <= 1'b0;
      BUSY_O <= 1'b0;
      TAKEN_O <= 1'b0;
      UNSUP_O <= 1'b0;
      PC_O <= 16'h0000;
      SP_O <= 16'h0000;
      B_O <= 8'h00;
      FLAGS_O <= 8'h00;
      BYTES_O <= 2'h0;
      MCYC_O <= 3'h0;
      TSTATES_O <= 5'h00;
    end else if (CE_I) begin
      DONE_O <= finish;
      BUSY_O <= (next_state != ST_IDLE);
      if (finish) begin
        TAKEN_O <= res_taken;
        UNSUP_O <= res_unsup;
        PC_O <= res_pc;
        SP_O <= res_sp;
        B_O <= res_b;
        FLAGS_O <= res_flags;            // see [RQ7]
        BYTES_O <= res_bytes;
        MCYC_O <= res_mcyc;
        TSTATES_O <= tcnt;
      end
    end
  end

  // ******
  // register port
  // ******
  // read data stand one cycle, zero otherwise
  wire logic wr_ctrl = REG_WR_I & (REG_ADDR_I == `BCR_REG_CTRL);
  wire logic wr_cnt = REG_WR_I & (REG_ADDR_I == `BCR_REG_TAKEN_CNT);
  wire logic cnt_inc = finish & res_taken;
  // a count arriving with the clear survives as one
  wire logic [7:0] next_cnt = cnt_inc ? (wr_cnt ? 8'h01 : taken_cnt + 8'h01) :
                              (wr_cnt ? 8'h00 : taken_cnt);
  wire logic [7:0] status_word = {5'h00, res_unsup, last_cond, BUSY_O};
  wire logic [7:0] rd_mux =
    (REG_ADDR_I == `BCR_REG_CTRL) ? ctrl :
    (REG_ADDR_I == `BCR_REG_STATUS) ? status_word :
    (REG_ADDR_I == `BCR_REG_LAST_T) ? {3'h0, TSTATES_O} :
    (REG_ADDR_I == `BCR_REG_TAKEN_CNT) ? taken_cnt :
    (REG_ADDR_I == `BCR_REG_LAST_OP) ? last_op : 8'h00;

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ctrl <= `BCR_CTRL_RESET;
      taken_cnt <= 8'h00;
      last_op <= 8'h00;
      last_cond <= 1'b0;
      REG_RDATA_O <= 8'h00;
    end else if (CE_I) begin
      if (wr_ctrl) begin
        ctrl <= {7'h00, REG_WDATA_I[`BCR_CTRL_EN_BIT]};
      end
      taken_cnt <= next_cnt;
      if (accept) begin
        last_op <= OPCODE_I;
        last_cond <= cond_ok;
      end
      REG_RDATA_O <= REG_RD_I ? rd_mux : 8'h00;
    end
  end

endmodule
`default_nettype wire

/* dv/bcr_unit_props.sv */
// timing, stack order and target checks for the branch, call and return unit
// assumes the inputs of an instruction stand still until its done pulse
`timescale 1ns/1ps
`default_nettype none

module bcr_unit_props (
  input wire logic CLK_I, RESETN_I, CE_I, EXEC_I, PREFIX_ED_I, // control
  input wire logic [7:0] OPCODE_I, B_I, FLAGS_I,              // instruction
  input wire logic [15:0] OPERAND_I, PC_I, SP_I,              // operands
  input wire logic BUSY_O, DONE_O, TAKEN_O, MEM_WR_O, MEM_RD_O, // status
  input wire logic [15:0] PC_O, SP_O, MEM_ADDR_O,             // addresses
  input wire logic [7:0] B_O, FLAGS_O,                        // results
  input wire logic [2:0] MCYC_O,                              // machine cycles
  input wire logic [4:0] TSTATES_O                            // clock states
);
  // ******
  // accept and condition decode
  // ******
  wire logic go = EXEC_I && CE_I && !BUSY_O && !PREFIX_ED_I;
  wire logic [7:0] cv = {FLAGS_I[7], !FLAGS_I[7], FLAGS_I[2], !FLAGS_I[2], FLAGS_I[0], !FLAGS_I[0], FLAGS_I[6],
    !FLAGS_I[6]};
  wire logic hold = cv[OPCODE_I[5:3]];
  wire logic grp = OPCODE_I[7:6] == 2'b11;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  // ******
  // properties
  // ******
  flags_kept_a: assert property (DONE_O |-> FLAGS_O == FLAGS_I)
    else $error("flags changed by a transfer");
  rel_taken_a: assert property (go && (OPCODE_I == 8'h18 || OPCODE_I == 8'h28 && FLAGS_I[6]) |->
    ##13 DONE_O && TSTATES_O == 5'h0c && MCYC_O == 3'h3 && PC_O == PC_I + 16'h2 + {{8{OPERAND_I[7]}}, OPERAND_I[7:0]})
    else $error("taken relative branch wrong");
  rel_skip_a: assert property (go && OPCODE_I == 8'h20 && FLAGS_I[6] |->
    ##8 DONE_O && TSTATES_O == 5'h07 && !TAKEN_O && PC_O == PC_I + 16'h2)
    else $error("relative fall through wrong");
  loop_end_a: assert property (go && OPCODE_I == 8'h10 && B_I == 8'h01 |->
    ##9 DONE_O && TSTATES_O == 5'h08 && B_O == 8'h00 && PC_O == PC_I + 16'h2)
    else $error("loop exit wrong");
  call_full_a: assert property (go && OPCODE_I == 8'hcd |->
    ##18 DONE_O && TSTATES_O == 5'h11 && MCYC_O == 3'h5 && PC_O == OPERAND_I && SP_O == SP_I - 16'h2)
    else $error("call result wrong");
  call_false_a: assert property (go && grp && OPCODE_I[2:0] == 3'h4 && !hold |->
    ##11 DONE_O && TSTATES_O == 5'h0a && !TAKEN_O && PC_O == PC_I + 16'h3)
    else $error("false conditional call wrong");
  call_true_a: assert property (go && grp && OPCODE_I[2:0] == 3'h4 && hold |->
    ##18 DONE_O && TAKEN_O && PC_O == OPERAND_I)
    else $error("true conditional call wrong");
  rst_vector_a: assert property (go && grp && OPCODE_I[2:0] == 3'h7 |->
    ##12 DONE_O && TSTATES_O == 5'h0b && PC_O == {10'h000, OPCODE_I[5:3], 3'h0} && SP_O == SP_I - 16'h2)
    else $error("restart result wrong");
  push_order_a: assert property ($rose(MEM_WR_O) |-> MEM_ADDR_O == SP_I - 16'h1
    ##1 MEM_WR_O && MEM_ADDR_O == SP_I - 16'h2 ##1 !MEM_WR_O)
    else $error("push order wrong");
  pop_order_a: assert property ($rose(MEM_RD_O) |-> MEM_ADDR_O == SP_I
    ##1 MEM_RD_O && MEM_ADDR_O == SP_I + 16'h1 ##1 !MEM_RD_O)
    else $error("pop order wrong");

  cover property (go && OPCODE_I == 8'hcd);
  cover property (go && grp && OPCODE_I[2:0] == 3'h7);
  cover property ($rose(MEM_RD_O));
endmodule

bind bcr_unit bcr_unit_props i_bcr_unit_props (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .CE_I(CE_I), .EXEC_I(EXEC_I),
  .PREFIX_ED_I(PREFIX_ED_I), .OPCODE_I(OPCODE_I), .B_I(B_I), .FLAGS_I(FLAGS_I), .OPERAND_I(OPERAND_I),
  .PC_I(PC_I), .SP_I(SP_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O), .TAKEN_O(TAKEN_O), .MEM_WR_O(MEM_WR_O),
  .MEM_RD_O(MEM_RD_O), .PC_O(PC_O), .SP_O(SP_O), .MEM_ADDR_O(MEM_ADDR_O), .B_O(B_O), .FLAGS_O(FLAGS_O),
  .MCYC_O(MCYC_O), .TSTATES_O(TSTATES_O));
`default_nettype wire

/* dv/bcr_unit_tb_top.sv */
// self-checking bench for the branch, call and return unit
// assumes the unit alone, its stack memory modelled here
`timescale 1ns/1ps
`default_nettype none

module bcr_unit_tb_top;
  logic clk_i = 1'b0, resetn_i = 1'b0, ce_i = 1'b1, exec_i = 1'b0, pre_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] code_i = 8'h00, b_i = 8'h00, flags_i = 8'h00, mem_rdata_i = 8'h00, reg_wdata_i = 8'h00;
  logic [15:0] opd_i = 16'h0000, inst_addr_i = 16'h0000, stk_i = 16'h0000;
  logic [3:0] reg_addr_i = 4'h0;
  logic busy_o, done_o, taken_o, unsup_o, mem_wr_o, mem_rd_o;
  logic [15:0] pc_o, sp_o, mem_addr_o;
  logic [7:0] b_o, flags_o, mem_wdata_o, reg_rdata_o, last_op;
  logic [1:0] bytes_o;
  logic [2:0] mcyc_o;
  logic [4:0] tstates_o, last_t;
  logic [7:0] mem [256];
  logic [23:0] wq [$];
  logic [31:0] seed = 32'h4edb;
  int error_cnt = 0, comparisons = 0, taken_sum = 0;

  always #2.5 clk_i = ~clk_i;

  bcr_unit i_bcr_unit (.CLK_I(clk_i), .RESETN_I(resetn_i), .CE_I(ce_i), .EXEC_I(exec_i), .PREFIX_ED_I(pre_i),
    .OPCODE_I(code_i), .OPERAND_I(opd_i), .PC_I(inst_addr_i), .SP_I(stk_i), .B_I(b_i), .FLAGS_I(flags_i),
    .MEM_RDATA_I(mem_rdata_i), .REG_ADDR_I(reg_addr_i), .REG_WDATA_I(reg_wdata_i), .REG_WR_I(reg_wr_i),
    .REG_RD_I(reg_rd_i), .BUSY_O(busy_o), .DONE_O(done_o), .TAKEN_O(taken_o), .UNSUP_O(unsup_o), .PC_O(pc_o),
    .SP_O(sp_o), .B_O(b_o), .FLAGS_O(flags_o), .BYTES_O(bytes_o), .MCYC_O(mcyc_o), .TSTATES_O(tstates_o),
    .MEM_WR_O(mem_wr_o), .MEM_RD_O(mem_rd_o), .MEM_ADDR_O(mem_addr_o), .MEM_WDATA_O(mem_wdata_o),
    .REG_RDATA_O(reg_rdata_o));

  // ******
  // stack memory, unread data keeps toggling
  // ******
  always @(posedge clk_i) begin
    if (mem_wr_o === 1'b1) begin
      wq.push_back({mem_addr_o, mem_wdata_o});
      mem[mem_addr_o[7:0]] <= mem_wdata_o;
    end
    mem_rdata_i <= (mem_rd_o === 1'b1) ? mem[mem_addr_o[7:0]] : ~mem_rdata_i;
  end

  // ******
  // helpers
  // ******
  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic cond(input logic [2:0] c, input logic [7:0] f);
    logic [7:0] v;
    v = {f[7], !f[7], f[2], !f[2], f[0], !f[0], f[6], !f[6]};
    return v[c];
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, v};
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp, input string name);
    @(posedge clk_i);
    {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check(name, reg_rdata_o, exp);
  endtask

  // ******
  // one instruction against the model
  // ******
  task automatic run_op(input logic pre, input logic [7:0] op, input logic [15:0] opd, ia, st,
    input logic [7:0] b, fl);
    logic [15:0] ep, es, ra, rl;
    logic [7:0] eb;
    logic tk, pu, po, un;
    logic [4:0] t;
    logic [2:0] m;
    logic [1:0] by;
    int n;
    rl = ia + 16'h2 + {{8{opd[7]}}, opd[7:0]};
    {es, eb, ra, pu, po, un} = {st, b, ia + 16'h3, 3'b000};
    tk = op[0] | cond(op[5:3], fl);
    if (pre) begin
      un = op != 8'h4d && op != 8'h45;
      {po, t, m, by} = {!un, 5'h0e, 3'h4, 2'h2};
    end else if (op == 8'h18) {tk, ep, t, m, by} = {1'b1, rl, 5'h0c, 3'h3, 2'h2};
    else if (op[7:5] == 3'b001 && op[2:0] == 3'h0) begin
      tk = cond({1'b0, op[4:3]}, fl);
      {ep, t, m, by} = tk ? {rl, 5'h0c, 3'h3, 2'h2} : {ia + 16'h2, 5'h07, 3'h2, 2'h2};
    end else if (op == 8'h10) begin
      eb = b - 8'h01;
      tk = eb != 8'h00;
      {ep, t, m, by} = tk ? {rl, 5'h0d, 3'h3, 2'h2} : {ia + 16'h2, 5'h08, 3'h2, 2'h2};
    end else if (op[7:6] == 2'b11 && op[2:0] != 3'h6 && (!op[0] || op[2:0] == 3'h7 || op == 8'hc3 || op == 8'hcd ||
      op == 8'hc9))
      case (op[2:1])
        2'b01: {ep, t, m, by} = {tk ? opd : ra, 5'h0a, 3'h3, 2'h3};
        2'b10: begin
          pu = tk;
          {ep, t, m, by} = tk ? {opd, 5'h11, 3'h5, 2'h3} : {ra, 5'h0a, 3'h3, 2'h3};
        end
        2'b00: begin
          po = tk;
          {ep, t, m, by} = tk ? {ia, op[0] ? 5'h0a : 5'h0b, 3'h3, 2'h1} : {ia + 16'h1, 5'h05, 3'h1, 2'h1};
        end
        default: begin
          {pu, ra} = {1'b1, ia + 16'h1};
          {ep, t, m, by} = {10'h000, op[5:3], 3'h0, 5'h0b, 3'h3, 2'h1};
        end
      endcase
    else un = 1'b1;
    if (un) {tk, ep, t, m} = {1'b0, ia + 16'h1, 5'h04, 3'h1};
    if (po) {ep, es} = {mem[8'(st + 16'h1)], mem[st[7:0]], st + 16'h2};
    if (pu) es = st - 16'h2;
    @(posedge clk_i);
    {exec_i, pre_i, code_i, opd_i, inst_addr_i, stk_i, b_i, flags_i} <= {1'b1, pre, op, opd, ia, st, b, fl};
    wq.delete();
    @(posedge clk_i);
    exec_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (done_o !== 1'b1 && n < 40);
    check("states seen", n, t);
    check("states", tstates_o, t);
    check("mcycles", mcyc_o, m);
    check("target", pc_o, ep);
    check("stack", sp_o, es);
    check("loop reg", b_o, eb);
    check("flags", flags_o, fl);
    check("taken", taken_o, tk);
    check("unsup", unsup_o, un);
    if (!un) check("bytes", bytes_o, by);
    check("pushes", wq.size(), pu ? 2 : 0);
    if (pu) check("push high", wq[0], {st - 16'h1, ra[15:8]});
    if (pu) check("push low", wq[1], {st - 16'h2, ra[7:0]});
    taken_sum += tk;
    {last_t, last_op} = {t, op};
  endtask

  task automatic run_rand(input logic pre, input logic [7:0] op, input logic [7:0] fl);
    run_op(pre, op, 16'(nxt()), 16'(nxt()), 16'(nxt()), 8'(nxt()), fl);
  endtask

  // ******
  // main sequence and watchdog
  // ******
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end

  initial begin
    logic [7:0] fl;
    logic sawdone = 1'b0;
    logic [7:0] ops [5] = '{8'h10, 8'hcd, 8'hc9, 8'hc3, 8'h00};
    for (int i = 0; i < 256; i++) mem[i] = 8'(nxt());
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    reg_rd(4'h0, 8'h01, "ctrl reset");
    reg_rd(4'h9, 8'h00, "unmapped");
    reg_wr(4'h3, 8'h00);
    run_op(1'b0, 8'h18, 16'h0080, 16'h1000, 16'h8000, 8'h00, 8'h00);
    run_op(1'b0, 8'h18, 16'h007f, 16'hfff0, 16'h8000, 8'h00, 8'hff);
    run_op(1'b0, 8'h10, 16'h00fe, 16'h2000, 16'h8000, 8'h01, 8'h00);
    run_op(1'b0, 8'h10, 16'h00fe, 16'h2000, 16'h8000, 8'h00, 8'h00);
    foreach (ops[k]) run_rand(1'b0, ops[k], 8'(nxt()));
    run_rand(1'b1, 8'h4d, 8'(nxt()));
    run_rand(1'b1, 8'h45, 8'(nxt()));
    for (int r = 0; r < 4; r++)
      for (int c = 0; c < 8; c++) begin
        fl = (r < 2) ? ((8'(nxt()) & 8'h3a) | (r == 1 ? 8'hc5 : 8'h00)) : 8'(nxt());
        if (c < 4) run_rand(1'b0, {3'b001, 2'(c), 3'h0}, fl);
        run_rand(1'b0, {2'b11, 3'(c), 3'h2}, fl);
        run_rand(1'b0, {2'b11, 3'(c), 3'h4}, fl);
        run_rand(1'b0, {2'b11, 3'(c), 3'h0}, fl);
        run_rand(1'b0, {2'b11, 3'(c), 3'h7}, fl);
      end
    reg_rd(4'h3, 8'(taken_sum), "taken count");
    reg_rd(4'h2, {3'h0, last_t}, "last states");
    reg_rd(4'h4, last_op, "last opcode");
    reg_rd(4'h1, {6'h00, fl[7], 1'b0}, "status");
    reg_wr(4'h2, 8'h55);
    reg_rd(4'h2, {3'h0, last_t}, "read only");
    reg_wr(4'h3, 8'h5a);
    reg_rd(4'h3, 8'h00, "count clear");
    reg_wr(4'h0, 8'h00);
    @(posedge clk_i);
    {exec_i, code_i} <= {1'b1, 8'hc3};
    @(posedge clk_i);
    exec_i <= 1'b0;
    repeat (30) @(posedge clk_i) sawdone |= (done_o !== 1'b0);
    check("refused", sawdone, 1'b0);
    reg_wr(4'h0, 8'h01);
    run_rand(1'b0, 8'hcd, 8'(nxt()));
    test_done();
  end
endmodule
`default_nettype wire
